// ### src/ifs_clock_switch.sv
// internal oscillator frequency select and glitch-free clock switch, APB slave
// How it works
// - a free 31 kHz low-frequency oscillator, uncalibrated, is modelled on-chip
// - the low-frequency wave also goes out to the power-up, watchdog and monitor timers
// - low oscillator runs when select is 000 and system clock select is 1
// - it also runs for power-up timer, watchdog, monitor, or two-speed start with 000
// - a status bit shows whether the low oscillator is stable
// - the 8 MHz source passes a postscaler; its taps and the 31 kHz source mux into the clock output
// - the 3-bit select picks one of eight frequencies, 8 MHz down to 31 kHz
// - any reset loads the select with 110, which is 4 MHz
// - switching to a stopped oscillator first waits out its start-up delay
// - a switch waits for a falling edge of the current clock, unless that clock has not settled and is already low
// - after that edge the output stays low until the new clock rises
// - on that rise the output follows the new clock and the switch completes
// - both stability flags always show the live state of their oscillators
// - moves among the 8 MHz to 125 kHz codes need no start-up delay
`timescale 1ns/10ps
module ifs_clock_switch import ifs_pkg::*; #(
  parameter int unsigned HF_STARTUP = HF_STARTUP_EDGES,
  parameter int unsigned LF_STARTUP = LF_STARTUP_EDGES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic clock_output_o,
  output logic lf_timer_clk_o,
  output logic low_freq_osc_en_o,
  output logic high_freq_osc_en_o,
  output logic low_osc_stable_flag_o,
  output logic high_osc_stable_flag_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ifs_ctrl_t ctrl_reg;
  ifs_sw_state_t state_reg;
  logic [2:0] active_reg;
  logic [2:0] target_reg;
  logic clk_out_reg;
  logic lf_en_reg;
  logic hf_en_reg;
  logic lf_tmr_reg;
  logic [7:0] lvl_prev_reg;
  logic lf_lvl;
  logic lf_rise;
  logic lf_stable;
  logic hf_lvl;
  logic hf_rise;
  logic hf_stable;
  logic [6:0] hf_tap;
  logic [7:0] lvls;
  logic [7:0] rises;
  logic [7:0] falls;
  logic lf_en_next;
  logic hf_en_next;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic [ADDR_W-1:0] addr;

  // ----------------------------------------------------------------
  // oscillators and postscaler
  // ----------------------------------------------------------------
  // the low oscillator is a divider; nothing trims it
  ifs_osc #(
    .HALF_CYC(LF_HALF_CYC),
    .STARTUP_EDGES(LF_STARTUP)
  ) u_lf_osc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .en_i(lf_en_reg),
    .lvl_o(lf_lvl),
    .rise_o(lf_rise),
    .stable_o(lf_stable)
  );

  ifs_osc #(
    .HALF_CYC(HF_HALF_CYC),
    .STARTUP_EDGES(HF_STARTUP)
  ) u_hf_osc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .en_i(hf_en_reg),
    .lvl_o(hf_lvl),
    .rise_o(hf_rise),
    .stable_o(hf_stable)
  );

  ifs_postscaler #(
    .STAGES(6)
  ) u_post (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .hf_lvl_i(hf_lvl),
    .hf_rise_i(hf_rise),
    .tap_o(hf_tap)
  );

  // mux inputs indexed by select code; code 0 is the low oscillator
  always_comb begin
    lvls = {hf_tap, lf_lvl};
    rises = lvls & ~lvl_prev_reg;
    falls = ~lvls & lvl_prev_reg;
  end

  // previous levels for edge detection on every tap
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_prev_reg <= '0;
    end else begin
      lvl_prev_reg <= lvls;
    end
  end

  function automatic logic code_stable(input logic [2:0] code, input logic lf_s, input logic hf_s);
    code_stable = (code == SEL_31KHZ) ? lf_s : hf_s;
  endfunction

  // ----------------------------------------------------------------
  // oscillator enables
  // ----------------------------------------------------------------
  // the low oscillator also runs while it is the source or target of a switch
  always_comb begin
    lf_en_next = (ctrl_reg.internal_freq_select == SEL_31KHZ && ctrl_reg.system_clock_select)
      || ctrl_reg.power_up_timer_en || ctrl_reg.watchdog_timer_en
      || ctrl_reg.fail_safe_clock_monitor_en
      || (ctrl_reg.two_speed_startup_enable && ctrl_reg.internal_freq_select == SEL_31KHZ)
      || active_reg == SEL_31KHZ
      || (state_reg != SW_IDLE && target_reg == SEL_31KHZ);
    // high oscillator stops only while the low one is the settled source, to save power
    hf_en_next = active_reg != SEL_31KHZ || (state_reg != SW_IDLE && target_reg != SEL_31KHZ);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lf_en_reg <= 1'b0;
      hf_en_reg <= 1'b0;
    end else begin
      lf_en_reg <= lf_en_next;
      hf_en_reg <= hf_en_next;
    end
  end

  // low wave handed to the timers, re-registered for a clean output
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lf_tmr_reg <= 1'b0;
    end else begin
      lf_tmr_reg <= lf_lvl;
    end
  end

  // ----------------------------------------------------------------
  // switch sequencer
  // ----------------------------------------------------------------
  // a new select taken mid-switch waits until the running switch completes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SW_IDLE;
      active_reg <= SEL_RESET;
      target_reg <= SEL_RESET;
      clk_out_reg <= 1'b0;
    end else begin
      case (state_reg)
        SW_IDLE: begin
          // output stays low until the active source has settled
          clk_out_reg <= lvls[active_reg] && code_stable(active_reg, lf_stable, hf_stable);
          if (ctrl_reg.internal_freq_select != active_reg) begin
            target_reg <= ctrl_reg.internal_freq_select;
            if (code_stable(ctrl_reg.internal_freq_select, lf_stable, hf_stable)) begin
              state_reg <= SW_WAIT_FALL;
            end else begin
              state_reg <= SW_STARTUP;
            end
          end
        end
        SW_STARTUP: begin
          clk_out_reg <= lvls[active_reg] && code_stable(active_reg, lf_stable, hf_stable);
          if (code_stable(target_reg, lf_stable, hf_stable)) begin
            state_reg <= SW_WAIT_FALL;
          end
        end
        SW_WAIT_FALL: begin
          // a source that never settled is already low, so no edge is awaited
          if (falls[active_reg] || !code_stable(active_reg, lf_stable, hf_stable)) begin
            clk_out_reg <= 1'b0;
            state_reg <= SW_HOLD_LOW;
          end else begin
            clk_out_reg <= lvls[active_reg];
          end
        end
        SW_HOLD_LOW: begin
          if (rises[target_reg]) begin
            clk_out_reg <= 1'b1;
            active_reg <= target_reg;
            state_reg <= SW_IDLE;
          end else begin
            clk_out_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= SW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, pready rises in the second access cycle
  // ----------------------------------------------------------------
  always_comb begin
    addr = paddr_i[ADDR_W-1:0];
    addr_ok = (paddr_i[31:ADDR_W] == '0) && (addr == ADDR_CTRL || addr == ADDR_STATUS);
    rdata_next = '0;
    if (addr == ADDR_CTRL) begin
      rdata_next[7:0] = ctrl_reg;
    end else if (addr == ADDR_STATUS) begin
      rdata_next[ST_LOW_STABLE] = lf_stable;
      rdata_next[ST_HIGH_STABLE] = hf_stable;
      rdata_next[ST_BUSY] = state_reg != SW_IDLE;
      rdata_next[ST_ACTIVE_LSB +: 3] = active_reg;
    end
    if (!addr_ok) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
      prdata_o <= (psel_i && penable_i && !pready_o && !pwrite_i) ? rdata_next : '0;
    end
  end

  // control write lands on the edge that completes the transfer; status is read-only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (psel_i && penable_i && pready_o && pwrite_i && addr_ok && addr == ADDR_CTRL) begin
      ctrl_reg <= pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    clock_output_o = clk_out_reg;
    lf_timer_clk_o = lf_tmr_reg;
    low_freq_osc_en_o = lf_en_reg;
    high_freq_osc_en_o = hf_en_reg;
    low_osc_stable_flag_o = lf_stable;
    high_osc_stable_flag_o = hf_stable;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESET_SELECT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> ctrl_reg.internal_freq_select == 3'h6 && active_reg == 3'h6)
    else $error("select not 110 after reset");

  AST_LF_ON_SELECT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ctrl_reg.internal_freq_select == 3'h0 && ctrl_reg.system_clock_select) |=> low_freq_osc_en_o)
    else $error("low oscillator off while selected");

  AST_LF_ON_TIMERS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ctrl_reg.watchdog_timer_en || ctrl_reg.power_up_timer_en || ctrl_reg.fail_safe_clock_monitor_en)
    |=> low_freq_osc_en_o)
    else $error("low oscillator off while a timer needs it");

  AST_STARTUP_WAIT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == SW_STARTUP && !code_stable(target_reg, lf_stable, hf_stable)) |=> state_reg == SW_STARTUP)
    else $error("switch left start-up before target was stable");

  AST_FALL_TO_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == SW_WAIT_FALL && falls[active_reg]) |=> state_reg == SW_HOLD_LOW && !clock_output_o)
    else $error("falling edge did not start the low hold");

  AST_HOLD_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == SW_HOLD_LOW && !rises[target_reg]) |=> !clock_output_o)
    else $error("clock output high during hold");

  AST_CONNECT_NEW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == SW_HOLD_LOW && rises[target_reg])
    |=> clock_output_o && state_reg == SW_IDLE && active_reg == $past(target_reg))
    else $error("new clock not connected on its rising edge");

  AST_NO_DELAY_HF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == SW_IDLE && hf_stable && active_reg != 3'h0
      && ctrl_reg.internal_freq_select != 3'h0 && ctrl_reg.internal_freq_select != active_reg)
    |=> state_reg == SW_WAIT_FALL)
    else $error("start-up delay inserted between high-side codes");

  AST_STATUS_LIVE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == 32'h4)
    |=> prdata_o[0] == $past(lf_stable) && prdata_o[1] == $past(hf_stable))
    else $error("status flags do not match oscillators");

endmodule // ifs_clock_switch

// ### src/ifs_osc.sv
// oscillator model: square wave from a divider, with a start-up delay before stable
`timescale 1ns/10ps
module ifs_osc import ifs_pkg::*; #(
  parameter int unsigned HALF_CYC = 15,
  parameter int unsigned STARTUP_EDGES = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  output logic lvl_o,
  output logic rise_o,
  output logic stable_o
);

  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam int unsigned SW = $clog2(STARTUP_EDGES + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);
  localparam logic [SW-1:0] START_LAST = SW'(STARTUP_EDGES);

  logic [CW-1:0] div_reg;
  logic [SW-1:0] start_reg;
  wire toggle = en_i && (div_reg == HALF_LAST);

  // ----------------------------------------------------------------
  // waveform: a disabled oscillator sits low
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= '0;
      lvl_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      div_reg <= (!en_i || toggle) ? '0 : div_reg + 1'b1;
      lvl_o <= en_i && (lvl_o ^ toggle);
      rise_o <= toggle && !lvl_o;
    end
  end

  // start-up delay counted on the oscillator's own edges
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_reg <= '0;
      stable_o <= 1'b0;
    end else if (!en_i) begin
      start_reg <= '0;
      stable_o <= 1'b0;
    end else if (rise_o && !stable_o) begin
      start_reg <= start_reg + 1'b1;
      stable_o <= (start_reg == START_LAST - 1'b1);
    end
  end

endmodule // ifs_osc

// ### src/ifs_pkg.sv
// shared constants and types for the internal oscillator select and switch block
package ifs_pkg;

  // ----------------------------------------------------------------
  // clock rates and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_FREQ_KHZ = 250000;
  localparam int unsigned HF_FREQ_KHZ = 8000;
  localparam int unsigned LF_FREQ_KHZ = 31;
  // half periods round down so no oscillator runs slower than nominal
  localparam int unsigned HF_HALF_CYC = MCLK_FREQ_KHZ / (2 * HF_FREQ_KHZ);
  localparam int unsigned LF_HALF_CYC = MCLK_FREQ_KHZ / (2 * LF_FREQ_KHZ);
  // start-up delays, in rising edges of the oscillator being started
  localparam int unsigned HF_STARTUP_EDGES = 16;
  localparam int unsigned LF_STARTUP_EDGES = 4;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int unsigned ADDR_W = 8;

  // frequency select codes
  localparam logic [2:0] SEL_8MHZ = 3'h7;
  localparam logic [2:0] SEL_4MHZ = 3'h6;
  localparam logic [2:0] SEL_31KHZ = 3'h0;
  localparam logic [2:0] SEL_RESET = SEL_4MHZ;

  // status field positions
  localparam int unsigned ST_LOW_STABLE = 0;
  localparam int unsigned ST_HIGH_STABLE = 1;
  localparam int unsigned ST_BUSY = 2;
  localparam int unsigned ST_ACTIVE_LSB = 3;

  // control register, bits 7:0 of the word
  typedef struct packed {
    logic two_speed_startup_enable;
    logic fail_safe_clock_monitor_en;
    logic watchdog_timer_en;
    logic power_up_timer_en;
    logic system_clock_select;
    logic [2:0] internal_freq_select;
  } ifs_ctrl_t;

  localparam ifs_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SEL_RESET};

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_STARTUP,
    SW_WAIT_FALL,
    SW_HOLD_LOW
  } ifs_sw_state_t;

endpackage

// ### src/ifs_postscaler.sv
// postscaler: divides the high-frequency wave into the seven high-side taps
`timescale 1ns/10ps
module ifs_postscaler import ifs_pkg::*; #(
  parameter int unsigned STAGES = 6
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hf_lvl_i,
  input wire logic hf_rise_i,
  output logic [STAGES:0] tap_o
);

  logic [STAGES-1:0] cnt_reg;

  // ripple count on high-frequency rising edges; a stopped wave leaves the count where it was
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (hf_rise_i) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // tap STAGES is the undivided wave, tap k is divided by 2^(STAGES-k)
  assign tap_o[STAGES] = hf_lvl_i;
  for (genvar k = 0; k < STAGES; k++) begin : g_tap
    assign tap_o[k] = cnt_reg[STAGES-1-k];
  end

endmodule // ifs_postscaler

// ### tb/ifs_clk_sink.sv
// clock consumer model: measures high times of the delivered clocks
`timescale 1ns/10ps
module ifs_clk_sink (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_i,
  input wire logic lf_clk_i,
  output logic [15:0] hi_len_o,
  output logic [15:0] lf_hi_o,
  output logic [15:0] min_hi_o
);
  logic [15:0] run_reg;
  logic [15:0] lf_run_reg;
  logic clk_d_reg;
  logic lf_d_reg;

  // ----------------------------------------
  // high-time counters
  // ----------------------------------------
  // a runt pulse from a bad switch shows up as a short minimum high time
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= 16'h0000;
      lf_run_reg <= 16'h0000;
      clk_d_reg <= 1'b0;
      lf_d_reg <= 1'b0;
      hi_len_o <= 16'h0000;
      lf_hi_o <= 16'h0000;
      min_hi_o <= 16'hffff;
    end else begin
      clk_d_reg <= clk_i;
      lf_d_reg <= lf_clk_i;
      run_reg <= clk_i ? run_reg + 16'h0001 : 16'h0000;
      lf_run_reg <= lf_clk_i ? lf_run_reg + 16'h0001 : 16'h0000;
      if (clk_d_reg && !clk_i) begin
        hi_len_o <= run_reg;
        if (run_reg < min_hi_o) begin
          min_hi_o <= run_reg;
        end
      end
      if (lf_d_reg && !lf_clk_i) begin
        lf_hi_o <= lf_run_reg;
      end
    end
  end
endmodule // ifs_clk_sink

// ### tb/ifs_clock_switch_tb.sv
// testbench for the internal oscillator select and clock switch
`timescale 1ns/10ps
module ifs_clock_switch_tb import ifs_pkg::*;;
  typedef struct packed {
    logic [7:0] ctrl;
    logic lf_en;
    logic [15:0] hi;
  } ifs_row_t;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic clk_out, lf_clk, lf_en, hf_en, ls, hs, rerr;
  logic [15:0] hi_len, lf_hi, min_hi;
  int num_errors = 0;
  int checked = 0;
  // code and enable bits beside expected low-osc enable and high time
  ifs_row_t rows [7] = '{
    '{8'h27, 1'b1, 16'h000f}, '{8'h05, 1'b0, 16'h003c}, '{8'h41, 1'b1, 16'h03c0},
    '{8'h86, 1'b0, 16'h001e}, '{8'h0a, 1'b0, 16'h01e0}, '{8'h13, 1'b1, 16'h00f0},
    '{8'h04, 1'b0, 16'h0078}};

  // ----------------------------------------
  // design and clock consumer
  // ----------------------------------------
  // short start-up counts keep the slow oscillator run affordable
  ifs_clock_switch #(.HF_STARTUP(2), .LF_STARTUP(1)) dut_u (.mclk_i(mclk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .clock_output_o(clk_out),
    .lf_timer_clk_o(lf_clk), .low_freq_osc_en_o(lf_en), .high_freq_osc_en_o(hf_en),
    .low_osc_stable_flag_o(ls), .high_osc_stable_flag_o(hs));
  ifs_clk_sink sink_u (.mclk_i(mclk), .rst_n_i(rst_n), .clk_i(clk_out), .lf_clk_i(lf_clk),
    .hi_len_o(hi_len), .lf_hi_o(lf_hi), .min_hi_o(min_hi));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    num_errors++;
    $display("MISMATCH %s expected done seen timeout", what);
    complete_run();
  endtask

  // one transfer; an idle edge after it keeps back-to-back calls race free
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up("apb_ready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rdat[ST_BUSY] !== 1'b0 && n < 12000);
    if (rdat[ST_BUSY] !== 1'b0) give_up("switch_busy");
  endtask

  // two full falls so the sink holds a whole pulse of the new clock
  task automatic meas();
    int n;
    int falls;
    logic prev;
    n = 0;
    falls = 0;
    prev = clk_out;
    while (falls < 2 && n < 30000) begin
      @(posedge mclk);
      if (prev === 1'b1 && clk_out === 1'b0) falls++;
      prev = clk_out;
      n++;
    end
    if (falls < 2) give_up("clock_fall");
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_reset", 32'h06, rdat);
    // the shortened fast start-up needs two rises, well inside eight half periods
    repeat (8 * HF_HALF_CYC) @(posedge mclk);
    wait_idle();
    chk("status_reset", 32'h32, rdat);
    apb(1'b0, 32'h8, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdat);
    apb(1'b1, ADDR_STATUS, 32'hff);
    chk("status_wr_err", 32'h0, {31'h0, rerr});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_ro", 32'h32, rdat);
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CTRL, {24'h0, rows[i].ctrl});
      wait_idle();
      chk("active_code", {29'h0, rows[i].ctrl[2:0]}, {29'h0, rdat[5:3]});
      chk("hf_stable", 32'h1, {31'h0, hs});
      chk("lf_enable", {31'h0, rows[i].lf_en}, {31'h0, lf_en});
      meas();
      chk("high_time", {16'h0, rows[i].hi}, {16'h0, hi_len});
    end
    // move to the slow oscillator with the system clock select set
    apb(1'b1, ADDR_CTRL, 32'h08);
    repeat (2) @(posedge mclk);
    chk("lf_enable_slow", 32'h1, {31'h0, lf_en});
    wait_idle();
    meas();
    chk("slow_high_time", LF_HALF_CYC, {16'h0, hi_len});
    chk("timer_high_time", LF_HALF_CYC, {16'h0, lf_hi});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_slow", 32'h01, rdat);
    chk("ls_flag", 32'h1, {31'h0, ls});
    chk("hf_enable_off", 32'h0, {31'h0, hf_en});
    // back to the stopped fast oscillator, which must start up first
    apb(1'b1, ADDR_CTRL, 32'h07);
    chk("hf_not_stable", 32'h0, {31'h0, hs});
    wait_idle();
    chk("status_back", 32'h3a, rdat & 32'h3e);
    meas();
    chk("fast_high_time", HF_HALF_CYC, {16'h0, hi_len});
    chk("min_high_time", HF_HALF_CYC, {16'h0, min_hi});
    // a second reset in mid-run must bring back the 4 MHz default and source
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rereset", 32'h06, rdat);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_rereset", 32'h30, rdat & 32'h3c);
    complete_run();
  end
endmodule // ifs_clock_switch_tb
